// ---- rmric_top.v ----
// Remote input functions, panel permissions, filter and totalizer control
`timescale 1ns/1ps
`default_nettype none
`include "rmric_map.vh"
module rmric_top #(
   parameter integer MIN_LOW_CYC = `RMRIC_MIN_LOW_CYC,
   parameter integer PRINT_CYC = `RMRIC_PRINT_CYC,
   parameter integer FILT_SCALE = `RMRIC_CLK_MHZ * 1000
) (
   // Clock and reset
   input wire REF_CLK,
   input wire RESET,
   // Remote inputs, active low
   input wire REMOTE_INPUT_ONE_N,
   input wire REMOTE_INPUT_TWO_N,
   // Configuration
   input wire [3:0] FUNC_ONE,
   input wire [3:0] FUNC_TWO,
   input wire EFFICIENCY_DISPLAY_CHOICE,
   input wire ALARM_OPTION,
   input wire [1:0] FILTER_LEVEL,
   input wire SHOW_ALARM_CFG,
   input wire ENTER_ALARM_CFG,
   input wire SHOW_HYST_CFG,
   input wire ENTER_HYST_CFG,
   input wire ALARM_LATCHING,
   input wire DISPLAY_SELECT_CFG,
   // Measurement side
   input wire PERIOD_DONE,
   input wire [19:0] LIVE_RATE,
   input wire [19:0] LIVE_SECONDARY,
   input wire RATE_ABOVE_CUTOFF,
   input wire TOTAL_COUNT_PULSE,
   input wire PANEL_TOGGLE,
   // Control outputs
   output reg RESTART_PERIOD,
   output reg TOTAL_CLEAR,
   output wire TOTAL_ENABLE,
   output reg [19:0] TOTAL,
   output reg TOTAL_FLASH,
   output wire HOLD_ACTIVE,
   output reg [19:0] SHOWN_RATE,
   output reg [19:0] SHOWN_SECONDARY,
   output wire [19:0] SERIAL_RATE,
   output reg PEAK_CLEAR,
   output reg VALLEY_CLEAR,
   output wire PEAK_TRACK,
   output wire VALLEY_TRACK,
   output reg ALARM_LATCH_RELEASE,
   output wire ALARM_FORCE_OFF,
   output reg SHOW_SECONDARY,
   output reg PRINT_REQUEST,
   output wire [31:0] FILTER_SETTLE_CYC,
   output wire ALARM_ENTRY_ALLOWED,
   output wire HYST_ENTRY_ALLOWED,
   output wire DISPLAY_SELECT_ALLOWED
);
   wire [1:0] act;
   wire [1:0] fall;
   wire [1:0] rise;
   wire [7:0] funcs = {FUNC_TWO, FUNC_ONE};
   reg [1:0] gate;
   reg [1:0] pending;
   reg trig_armed;
   reg [31:0] print_count [0:1];
   reg next_restart;
   reg next_tclear;
   reg next_pclear;
   reg next_vclear;
   reg next_arel;
   reg next_toggle;
   reg next_print;
   reg [1:0] next_gate;
   reg [1:0] next_pending;
   reg hold;
   reg trig;
   reg track_p;
   reg track_v;
   reg ovr;
   reg gate_use;
   reg [3:0] f;
   reg [31:0] pc0;
   reg [31:0] pc1;
   integer i;
   integer j;

   ////////////////////////////////////////////////////////////////////
   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : chan
         rmric_input #(.MIN_LOW_CYC(MIN_LOW_CYC)) u_in (
            .clk(REF_CLK),
            .reset(RESET),
            .pin_n(g == 0 ? REMOTE_INPUT_ONE_N : REMOTE_INPUT_TWO_N),
            .active(act[g]),
            .fall(fall[g]),
            .rise(rise[g])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////
   // Events from both inputs; input one is decoded first, so when both
   // edges land together its action is issued and input two's waits
   always @* begin
      next_restart = 1'b0;
      next_tclear = 1'b0;
      next_pclear = 1'b0;
      next_vclear = 1'b0;
      next_arel = 1'b0;
      next_toggle = 1'b0;
      next_print = 1'b0;
      next_gate = gate;
      next_pending = 2'h0;
      hold = 1'b0;
      trig = 1'b0;
      track_p = 1'b0;
      track_v = 1'b0;
      ovr = 1'b0;
      gate_use = 1'b0;
      for (i = 0; i < 2; i = i + 1) begin
         f = funcs[i*4 +: 4];
         // Input two's edge deferred one cycle behind input one
         if ((i == 0 && fall[0]) || (i == 1 && pending[1])) begin
            case (f)
               `RMRIC_FN_RESTART: next_restart = 1'b1;
               `RMRIC_FN_TOT_CLR:
                  if (!EFFICIENCY_DISPLAY_CHOICE)
                     next_tclear = 1'b1;
               `RMRIC_FN_TOT_GATE_CLR:
                  if (!EFFICIENCY_DISPLAY_CHOICE) begin
                     next_tclear = 1'b1;
                     next_gate[i] = 1'b1;
                  end
               `RMRIC_FN_PV_CLR: begin
                  next_pclear = 1'b1;
                  next_vclear = 1'b1;
               end
               `RMRIC_FN_PEAK: next_pclear = 1'b1;
               `RMRIC_FN_VALLEY: next_vclear = 1'b1;
               `RMRIC_FN_ALM_RST: next_arel = ALARM_OPTION;
               `RMRIC_FN_TOGGLE: next_toggle = 1'b1;
               `RMRIC_FN_TRIG: next_restart = 1'b1;
               `RMRIC_FN_PRINT: next_print = 1'b1;
               default: next_restart = next_restart;
            endcase
         end
         if (i == 1 && fall[1])
            next_pending[1] = 1'b1;
         if (rise[i] || f != `RMRIC_FN_TOT_GATE_CLR)
            next_gate[i] = 1'b0;
         case (f)
            `RMRIC_FN_TOT_GATE_CLR: gate_use = 1'b1;
            `RMRIC_FN_TOT_GATE: gate_use = 1'b1;
            `RMRIC_FN_HOLD: hold = hold | act[i];
            `RMRIC_FN_PEAK: track_p = track_p | act[i];
            `RMRIC_FN_VALLEY: track_v = track_v | act[i];
            `RMRIC_FN_ALM_OVR: ovr = ovr | (act[i] & ALARM_OPTION);
            `RMRIC_FN_TRIG: trig = 1'b1;
            default: trig = trig;
         endcase
      end
   end

   // Gated totalizing: code 2 by latched gate, code 3 by level
   wire gate_open = ((FUNC_ONE == `RMRIC_FN_TOT_GATE_CLR) & gate[0])
      | ((FUNC_ONE == `RMRIC_FN_TOT_GATE) & act[0])
      | ((FUNC_TWO == `RMRIC_FN_TOT_GATE_CLR) & gate[1])
      | ((FUNC_TWO == `RMRIC_FN_TOT_GATE) & act[1]);
   assign TOTAL_ENABLE = !EFFICIENCY_DISPLAY_CHOICE
      & (gate_use ? gate_open : 1'b1)
      & (trig ? RATE_ABOVE_CUTOFF : 1'b1);
   assign HOLD_ACTIVE = hold;
   assign PEAK_TRACK = track_p;
   assign VALLEY_TRACK = track_v;
   assign ALARM_FORCE_OFF = ovr;
   // Serial read returns what is shown while held
   assign SERIAL_RATE = hold ? SHOWN_RATE : LIVE_RATE;

   ////////////////////////////////////////////////////////////////////
   // Print repeats every 800 ms of continued low
   always @* begin
      pc0 = print_count[0];
      pc1 = print_count[1];
   end

   always @(posedge REF_CLK) begin
      if (RESET) begin
         print_count[0] <= 32'h0;
         print_count[1] <= 32'h0;
      end else begin
         for (j = 0; j < 2; j = j + 1) begin
            if (!act[j] || funcs[j*4 +: 4] != `RMRIC_FN_PRINT)
               print_count[j] <= 32'h0;
            else if (print_count[j] >= PRINT_CYC - 1)
               print_count[j] <= 32'h0;
            else
               print_count[j] <= print_count[j] + 32'h1;
         end
      end
   end

   wire print_again = (act[0] && FUNC_ONE == `RMRIC_FN_PRINT
      && pc0 == PRINT_CYC - 1) || (act[1] && FUNC_TWO == `RMRIC_FN_PRINT
      && pc1 == PRINT_CYC - 1);

   ////////////////////////////////////////////////////////////////////
   always @(posedge REF_CLK) begin
      if (RESET) begin
         RESTART_PERIOD <= 1'b0;
         TOTAL_CLEAR <= 1'b0;
         PEAK_CLEAR <= 1'b0;
         VALLEY_CLEAR <= 1'b0;
         ALARM_LATCH_RELEASE <= 1'b0;
         PRINT_REQUEST <= 1'b0;
         SHOW_SECONDARY <= 1'b0;
         gate <= 2'h0;
         pending <= 2'h0;
         trig_armed <= 1'b0;
         SHOWN_RATE <= 20'h0;
         SHOWN_SECONDARY <= 20'h0;
         TOTAL <= 20'h0;
         TOTAL_FLASH <= 1'b0;
      end else begin
         RESTART_PERIOD <= next_restart;
         TOTAL_CLEAR <= next_tclear;
         PEAK_CLEAR <= next_pclear;
         VALLEY_CLEAR <= next_vclear;
         ALARM_LATCH_RELEASE <= next_arel;
         PRINT_REQUEST <= next_print | print_again;
         gate <= next_gate;
         pending <= next_pending;
         // Display toggle; panel toggle only when selection allowed
         if (next_toggle || (PANEL_TOGGLE && DISPLAY_SELECT_CFG))
            SHOW_SECONDARY <= !SHOW_SECONDARY;
         // Triggered mode: one update per completed triggered period
         if (trig && next_restart)
            trig_armed <= 1'b1;
         else if (trig && PERIOD_DONE)
            trig_armed <= 1'b0;
         if (hold) begin
            SHOWN_RATE <= SHOWN_RATE;
         end else if (trig) begin
            if (PERIOD_DONE && trig_armed) begin
               SHOWN_RATE <= LIVE_RATE;
               SHOWN_SECONDARY <= EFFICIENCY_DISPLAY_CHOICE ?
                  LIVE_SECONDARY : TOTAL;
            end
         end else begin
            SHOWN_RATE <= LIVE_RATE;
            SHOWN_SECONDARY <= EFFICIENCY_DISPLAY_CHOICE ?
               LIVE_SECONDARY : TOTAL;
         end
         // Totalizer with rollover flag; clear wins over counting
         if (next_tclear) begin
            TOTAL <= 20'h0;
            TOTAL_FLASH <= 1'b0;
         end else if (TOTAL_COUNT_PULSE && TOTAL_ENABLE) begin
            if (TOTAL == `RMRIC_TOTAL_MAX) begin
               TOTAL <= 20'h0;
               TOTAL_FLASH <= 1'b1;
            end else begin
               TOTAL <= TOTAL + 20'h1;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Panel permissions
   assign ALARM_ENTRY_ALLOWED = ALARM_OPTION & SHOW_ALARM_CFG
      & ENTER_ALARM_CFG;
   assign HYST_ENTRY_ALLOWED = ALARM_OPTION & SHOW_HYST_CFG
      & ENTER_HYST_CFG & !ALARM_LATCHING;
   assign DISPLAY_SELECT_ALLOWED = DISPLAY_SELECT_CFG;

   // Worst-case filter settling time in clock cycles
   reg [31:0] settle_ms;
   always @* begin
      case (FILTER_LEVEL)
         2'h0: settle_ms = `RMRIC_FILT0_MS;
         2'h1: settle_ms = `RMRIC_FILT1_MS;
         2'h2: settle_ms = `RMRIC_FILT2_MS;
         default: settle_ms = `RMRIC_FILT3_MS;
      endcase
   end
   assign FILTER_SETTLE_CYC = settle_ms * FILT_SCALE;
endmodule
`default_nettype wire

// ---- rmric_map.vh ----
// Constants for the rate meter remote input control block
// Contract
// - Both asserted: first input's function acts first
// - Code 0 falling edge restarts measurement period
// - Code 1 edge clears total, keeps totalizing
// - Code 2 edge clears, gates totalizer while low
// - Code 3 totalizes only while input low
// - Code 4 low freezes display, captures secondary
// - Hold active: serial rate answers frozen value
// - Code 5 edge clears peak and valley
// - Code 6 clears peak, tracks while low
// - Code 7 clears valley, tracks while low
// - Code 8 edge releases latched alarms
// - Code 9 low forces alarms inactive
// - Code 10 falling edge toggles display
// - Code 11 triggered rate, frozen between triggers
// - Code 12 requests print, repeat after 800 ms
// - Second input has same independent functions
// - Filter levels 0..3 with settling limits
// - Alarm entry forced off when alarm display off
// - Hysteresis entry off if hidden or latching
// - Display select off keeps current display; a code 10 input still toggles it
// - Total above 999999 rolls over and flashes
`ifndef RMRIC_MAP_VH
`define RMRIC_MAP_VH
`define RMRIC_CLK_MHZ 200
`define RMRIC_MIN_LOW_MS 20
`define RMRIC_MIN_LOW_CYC (`RMRIC_MIN_LOW_MS * 1000 * `RMRIC_CLK_MHZ)
`define RMRIC_PRINT_MS 800
`define RMRIC_PRINT_CYC (`RMRIC_PRINT_MS * 1000 * `RMRIC_CLK_MHZ)
`define RMRIC_FILT0_MS 1500
`define RMRIC_FILT1_MS 2000
`define RMRIC_FILT2_MS 6000
`define RMRIC_FILT3_MS 13000
`define RMRIC_TOTAL_MAX 20'hf423f
`define RMRIC_FN_RESTART 4'h0
`define RMRIC_FN_TOT_CLR 4'h1
`define RMRIC_FN_TOT_GATE_CLR 4'h2
`define RMRIC_FN_TOT_GATE 4'h3
`define RMRIC_FN_HOLD 4'h4
`define RMRIC_FN_PV_CLR 4'h5
`define RMRIC_FN_PEAK 4'h6
`define RMRIC_FN_VALLEY 4'h7
`define RMRIC_FN_ALM_RST 4'h8
`define RMRIC_FN_ALM_OVR 4'h9
`define RMRIC_FN_TOGGLE 4'ha
`define RMRIC_FN_TRIG 4'hb
`define RMRIC_FN_PRINT 4'hc
`endif

// ---- rmric_input.v ----
// One remote input: synchroniser, minimum-low filter, edge detector
`timescale 1ns/1ps
`default_nettype none
module rmric_input #(
   parameter integer MIN_LOW_CYC = 4000000
) (
   input wire clk,
   input wire reset,
   input wire pin_n,
   output reg active,
   output reg fall,
   output reg rise
);
   reg sync1;
   reg sync2;
   reg [31:0] low_count;

   // Two flops before anything reads the pin
   always @(posedge clk) begin
      if (reset) begin
         sync1 <= 1'b1;
         sync2 <= 1'b1;
      end else begin
         sync1 <= pin_n;
         sync2 <= sync1;
      end
   end

   // Low must persist before it counts; release is immediate
   always @(posedge clk) begin
      if (reset) begin
         low_count <= 32'h0;
         active <= 1'b0;
         fall <= 1'b0;
         rise <= 1'b0;
      end else begin
         fall <= 1'b0;
         rise <= 1'b0;
         if (sync2) begin
            low_count <= 32'h0;
            if (active) begin
               active <= 1'b0;
               rise <= 1'b1;
            end
         end else if (!active) begin
            if (low_count >= MIN_LOW_CYC - 1) begin
               active <= 1'b1;
               fall <= 1'b1;
            end else begin
               low_count <= low_count + 32'h1;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ---- rmric_contacts.sv ----
// Partner model: contact closures to signal common on both remote inputs
`timescale 1ns/1ps
`default_nettype none
module rmric_contacts (
   // Pacing clock
   input wire logic clk,
   // Remote pins, pulled up while the contacts are open
   output var logic pin_one_n,
   output var logic pin_two_n
);
initial begin
   pin_one_n = 1'b1;
   pin_two_n = 1'b1;
end
// Callers keep n above the filter length except when probing short-low rejection
task automatic press(input logic [1:0] sel, input int n);
   @(posedge clk);
   if (sel[0]) pin_one_n <= 1'b0;
   if (sel[1]) pin_two_n <= 1'b0;
   repeat (n) @(posedge clk);
   pin_one_n <= 1'b1;
   pin_two_n <= 1'b1;
endtask
endmodule
`default_nettype wire

// ---- rmric_top_monitor.sv ----
// Checker for the remote input control block
`timescale 1ns/1ps
`default_nettype none
module rmric_top_monitor #(
   parameter int MIN_LOW_CYC = 8,
   parameter int FILT_SCALE = 200000
) (
   // Clock, reset and remote inputs
   input wire logic REF_CLK,
   input wire logic RESET,
   input wire logic REMOTE_INPUT_ONE_N,
   input wire logic REMOTE_INPUT_TWO_N,
   input wire logic [3:0] FUNC_ONE,
   input wire logic [3:0] FUNC_TWO,
   // Panel permissions and filter
   input wire logic SHOW_ALARM_CFG,
   input wire logic SHOW_HYST_CFG,
   input wire logic ALARM_LATCHING,
   input wire logic ALARM_ENTRY_ALLOWED,
   input wire logic HYST_ENTRY_ALLOWED,
   input wire logic [1:0] FILTER_LEVEL,
   input wire logic [31:0] FILTER_SETTLE_CYC,
   // Display, totalizer and actions
   input wire logic HOLD_ACTIVE,
   input wire logic [19:0] LIVE_RATE,
   input wire logic [19:0] SHOWN_RATE,
   input wire logic [19:0] SERIAL_RATE,
   input wire logic [19:0] TOTAL,
   input wire logic RESTART_PERIOD,
   input wire logic PRINT_REQUEST
);
default clocking @(posedge REF_CLK); endclocking
default disable iff (RESET);
// Fixed repeat counts: the bench runs the filter at 8 cycles
sequence s_one_press;
   $fell(REMOTE_INPUT_ONE_N) ##1
      (!REMOTE_INPUT_ONE_N && FUNC_ONE == 4'h0) [*8];
endsequence
sequence s_two_print;
   $fell(REMOTE_INPUT_TWO_N) ##1
      (!REMOTE_INPUT_TWO_N && FUNC_TWO == 4'hc) [*8];
endsequence
sequence s_one_glitch;
   $fell(REMOTE_INPUT_ONE_N) ##1 !REMOTE_INPUT_ONE_N [*4]
      ##1 REMOTE_INPUT_ONE_N;
endsequence
a_restart_one: assert property (
   s_one_press |-> ##[1:MIN_LOW_CYC] RESTART_PERIOD)
   else $error("restart pulse missing");
a_print_two: assert property (
   s_two_print |-> ##[1:MIN_LOW_CYC] PRINT_REQUEST)
   else $error("print request missing");
a_glitch_ignored: assert property (
   s_one_glitch |=> !RESTART_PERIOD [*8])
   else $error("short low acted upon");
a_serial_rate: assert property (
   SERIAL_RATE == (HOLD_ACTIVE ? SHOWN_RATE : LIVE_RATE))
   else $error("serial rate source wrong");
a_hold_frozen: assert property (
   HOLD_ACTIVE && $past(HOLD_ACTIVE) |-> SERIAL_RATE == $past(SERIAL_RATE))
   else $error("held serial rate moved");
a_alarm_entry: assert property (
   !SHOW_ALARM_CFG |-> !ALARM_ENTRY_ALLOWED)
   else $error("alarm entry not forced off");
a_hyst_entry: assert property (
   (!SHOW_HYST_CFG || ALARM_LATCHING) |-> !HYST_ENTRY_ALLOWED)
   else $error("hysteresis entry not forced off");
a_total_range: assert property (
   TOTAL <= 20'hf423f)
   else $error("total above six digits");
a_filter_settle: assert property (
   FILTER_SETTLE_CYC == 32'(FILT_SCALE) * (FILTER_LEVEL == 2'h0 ?
   32'h5dc : FILTER_LEVEL == 2'h1 ? 32'h7d0 : FILTER_LEVEL == 2'h2 ?
   32'h1770 : 32'h32c8))
   else $error("settling figure wrong");
endmodule
bind rmric_top rmric_top_monitor #(.MIN_LOW_CYC(MIN_LOW_CYC),
   .FILT_SCALE(FILT_SCALE)) mon_u (.REF_CLK(REF_CLK), .RESET(RESET),
   .REMOTE_INPUT_ONE_N(REMOTE_INPUT_ONE_N), .FUNC_ONE(FUNC_ONE),
   .REMOTE_INPUT_TWO_N(REMOTE_INPUT_TWO_N), .FUNC_TWO(FUNC_TWO),
   .SHOW_ALARM_CFG(SHOW_ALARM_CFG), .SHOW_HYST_CFG(SHOW_HYST_CFG),
   .ALARM_LATCHING(ALARM_LATCHING), .FILTER_LEVEL(FILTER_LEVEL),
   .ALARM_ENTRY_ALLOWED(ALARM_ENTRY_ALLOWED), .TOTAL(TOTAL),
   .HYST_ENTRY_ALLOWED(HYST_ENTRY_ALLOWED), .LIVE_RATE(LIVE_RATE),
   .FILTER_SETTLE_CYC(FILTER_SETTLE_CYC), .HOLD_ACTIVE(HOLD_ACTIVE),
   .SHOWN_RATE(SHOWN_RATE), .SERIAL_RATE(SERIAL_RATE),
   .RESTART_PERIOD(RESTART_PERIOD), .PRINT_REQUEST(PRINT_REQUEST));
`default_nettype wire

// ---- rmric_top_tb.sv ----
// Self-checking bench for the remote input control block
`timescale 1ns/1ps
`default_nettype none
module rmric_top_tb;
`define CHK(n, e, g) begin \
   compares++; \
   if ((g) !== (e)) begin \
      n_errors++; \
      $display("wrong value %s exp %0h got %0h", n, e, g); \
   end \
end
logic clk = 1'b0, rst = 1'b1, eff = 1'b0, alm = 1'b1, dsel = 1'b1;
logic sa = 1'b0, ea = 1'b0, sh = 1'b0, eh = 1'b0, lat = 1'b0;
logic pdone = 1'b0, cnt_p = 1'b0, ptog = 1'b0;
logic [3:0] f1 = 4'hd, f2 = 4'hd;
logic [1:0] flt = 2'h0;
logic [19:0] live = 20'h0;
wire p1, p2, tot_en, tflash, hold, ptrk, vtrk, frc, shsec, alw_a, alw_h;
wire [19:0] total, srate, shrate, shsecv;
wire [31:0] settle;
wire [5:0] pul;
int n_errors = 0, compares = 0, cyc = 0, cnt[6], first[6];
int ms[4] = '{1500, 2000, 6000, 13000}, refused[5] = '{1, 2, 3, 8, 9};
// {toggle, enable after, force, valley, peak, hold, pulses}
localparam logic [11:0] EXP[13] = '{12'h401, 12'h402, 12'h002, 12'h000,
   12'h440, 12'h40c, 12'h484, 12'h508, 12'h410, 12'h600, 12'hc00,
   12'h401, 12'h420};
initial forever #2.5 clk = ~clk;
rmric_contacts cont_u (.clk(clk), .pin_one_n(p1), .pin_two_n(p2));
rmric_top #(.MIN_LOW_CYC(8), .PRINT_CYC(20), .FILT_SCALE(10)) dut_u (
   .REF_CLK(clk), .RESET(rst), .REMOTE_INPUT_ONE_N(p1),
   .REMOTE_INPUT_TWO_N(p2), .FUNC_ONE(f1), .FUNC_TWO(f2),
   .EFFICIENCY_DISPLAY_CHOICE(eff), .ALARM_OPTION(alm), .FILTER_LEVEL(flt),
   .SHOW_ALARM_CFG(sa), .ENTER_ALARM_CFG(ea), .SHOW_HYST_CFG(sh),
   .ENTER_HYST_CFG(eh), .ALARM_LATCHING(lat), .DISPLAY_SELECT_CFG(dsel),
   .PERIOD_DONE(pdone), .LIVE_RATE(live), .LIVE_SECONDARY(20'h0),
   .RATE_ABOVE_CUTOFF(1'b1), .TOTAL_COUNT_PULSE(cnt_p),
   .PANEL_TOGGLE(ptog), .RESTART_PERIOD(pul[0]), .TOTAL_CLEAR(pul[1]),
   .TOTAL_ENABLE(tot_en), .TOTAL(total), .TOTAL_FLASH(tflash),
   .HOLD_ACTIVE(hold), .SHOWN_RATE(shrate), .SHOWN_SECONDARY(shsecv),
   .SERIAL_RATE(srate), .PEAK_CLEAR(pul[2]), .VALLEY_CLEAR(pul[3]),
   .PEAK_TRACK(ptrk), .VALLEY_TRACK(vtrk), .ALARM_LATCH_RELEASE(pul[4]),
   .ALARM_FORCE_OFF(frc), .SHOW_SECONDARY(shsec), .PRINT_REQUEST(pul[5]),
   .FILTER_SETTLE_CYC(settle), .ALARM_ENTRY_ALLOWED(alw_a),
   .HYST_ENTRY_ALLOWED(alw_h), .DISPLAY_SELECT_ALLOWED());
task automatic wrap_up;
   $display("errors %0d compares %0d", n_errors, compares);
   if (n_errors == 0 && compares > 0)
      $display("bench passed");
   else
      $display("bench failed");
   $finish;
endtask
// Period ticks, pulse tally and the hang guard
always @(posedge clk) begin
   cyc <= cyc + 1;
   pdone <= (cyc % 16 == 0);
   for (int i = 0; i < 6; i++)
      if (pul[i] === 1'b1) begin
         if (cnt[i] == 0) first[i] <= cyc;
         cnt[i] <= cnt[i] + 1;
      end
   if (cyc == 6000) begin
      n_errors++;
      wrap_up();
   end
end
task automatic cycles(input int n);
   repeat (n) @(posedge clk);
   #1;
endtask
task automatic clr;
   @(posedge clk);
   foreach (cnt[i]) cnt[i] = 0;
endtask
task automatic tick(input int n);
   repeat (n) begin
      @(posedge clk);
      cnt_p <= 1'b1;
      @(posedge clk);
      cnt_p <= 1'b0;
   end
endtask
task automatic run_code(input int w, input int c, input logic [11:0] e);
   logic s0;
   logic [4:0] lv;
   logic [5:0] pv;
   @(posedge clk);
   if (w == 1) f1 <= c[3:0]; else f2 <= c[3:0];
   clr();
   s0 = shsec;
   fork
      cont_u.press(w[1:0], 30);
      begin
         cycles(22);
         lv = {tot_en, frc, vtrk, ptrk, hold};
      end
   join
   cycles(6);
   foreach (pv[i]) pv[i] = cnt[i] != 0;
   `CHK("levels", {~eff, e[9:6]}, lv)
   `CHK("pulses", e[5:0], pv)
   `CHK("enable after", e[10], tot_en)
   `CHK("toggle", e[11], s0 ^ shsec)
   @(posedge clk);
   f1 <= 4'hd;
   f2 <= 4'hd;
endtask
initial begin
   repeat (2) @(posedge clk);
   rst <= 1'b0;
   for (int w = 1; w <= 2; w++)
      for (int c = 0; c <= 12; c++)
         run_code(w, c, EXP[c]);
   @(posedge clk);
   eff <= 1'b1;
   alm <= 1'b0;
   foreach (refused[i]) run_code(1, refused[i], 12'h000);
   @(posedge clk);
   eff <= 1'b0;
   alm <= 1'b1;
   f1 <= 4'h0;
   f2 <= 4'hc;
   clr();
   cont_u.press(2'h3, 30);
   cycles(6);
   `CHK("first acts first", 1, first[5] - first[0])
   clr();
   cont_u.press(2'h1, 5);
   cycles(15);
   `CHK("short low", 0, cnt[0])
   clr();
   cont_u.press(2'h2, 60);
   cycles(6);
   `CHK("print repeat", 1'b1, cnt[5] >= 2)
   // Hold freezes the shown rate while the live value moves
   @(posedge clk);
   f2 <= 4'hd;
   f1 <= 4'h4;
   live <= 20'h64;
   cycles(40);
   fork
      cont_u.press(2'h1, 40);
      begin
         cycles(20);
         live <= 20'hc8;
         cycles(5);
         `CHK("serial rate", 20'h64, srate)
         `CHK("held rate", 20'h64, shrate)
      end
   join
   cycles(40);
   f1 <= 4'hb;
   cycles(4);
   live <= 20'h12c;
   cycles(40);
   `CHK("triggered frozen", 20'hc8, shrate)
   cont_u.press(2'h1, 20);
   cycles(40);
   `CHK("triggered update", 20'h12c, shrate)
   // Gated count: only pulses while low reach the total
   f1 <= 4'h2;
   fork
      cont_u.press(2'h1, 30);
      begin
         cycles(20);
         tick(3);
      end
   join
   cycles(6);
   tick(2);
   cycles(2);
   `CHK("gated total", 20'h3, total)
   `CHK("flash", 1'b0, tflash)
   for (int k = 0; k < 4; k++) begin
      dsel <= k[1];
      ptog <= 1'b1;
      cycles(1);
      ptog <= 1'b0;
      cycles(3);
      `CHK("panel toggle", k[1] & ~k[0], shsec)
   end
   for (int k = 0; k < 32; k++) begin
      {lat, sa, ea, sh, eh} <= k[4:0];
      cycles(1);
      `CHK("alarm entry", sa & ea, alw_a)
      `CHK("hyst entry", sh & eh & ~lat, alw_h)
   end
   for (int l = 0; l < 4; l++) begin
      flt <= l[1:0];
      cycles(1);
      `CHK("settle", 32'(ms[l] * 10), settle)
   end
   wrap_up();
end
endmodule
`default_nettype wire
